// *** cfp_core.sv ***
// CPU control core: fetch pointer, flag register, interrupt, low-power and break sequencing.
// Overview of operation
// - 16-bit fetch pointer, increments on sequential fetch.
// - Jumps, taken branches, interrupts load targets.
// - Reset loads fetch pointer from top vector.
// - Flag bits 6 and 5 always read one.
// - Signed overflow sets wrap flag; branches use it.
// - Add sets nibble carry from bit 3.
// - Decimal adjust corrects using nibble carry, carry.
// - Mask set blocks maskable requests; clear accepts.
// - Entry pushes registers, sets mask, fetches vector.
// - Index upper byte is never pushed on entry.
// - Highest-priority pending request is served first.
// - Interrupt return pulls registers, restores mask.
// - Reset sets mask; mask-clear op, wait, stop or pulled flags clear it.
// - Sign flag copies result bit 7.
// - Zero flag set when result is zero.
// - Carry out of bit 7; shifts update it.
// - Wait clears mask, stops clock, exits by interrupt.
// - Stop clears mask; restart after stabilization delay.
// - Break forces trap opcode, loads break or monitor vector.
// - Break starts after current instruction completes.
// - Return in break ends break once released.
// - Immediate signed adds: two cycles, no flags.
//
// The implementer's own choices: strobed register access and the register offsets.
`include "cfp_params.svh"
module cfp_core #(
  parameter int         NIRQ         = 4,
  parameter int         STAB_CYCLES  = `CFP_STAB_CYC,
  parameter logic [7:0] SOFT_TRAP_OP = `CFP_SOFT_TRAP
) (
  input  logic              clk,
  input  logic              rst,
  input  logic [3:0]        regAddr,
  input  logic [15:0]       regWrData,
  input  logic              regWr,
  input  logic              regRd,
  output logic [15:0]       regRdData,
  input  logic              cmdValid,
  input  cfp_pkg::cfp_cmd_s cmd,
  output logic              cmdReady,
  input  logic [NIRQ-1:0]   irqReq,
  output logic [NIRQ-1:0]   irqAck,
  input  logic              brkReq,
  input  logic              monMode,
  output logic [15:0]       memAddr,
  output logic              memRd,
  output logic              memWr,
  output logic [7:0]        memWrData,
  input  logic [7:0]        memRdData,
  output logic [15:0]       fetchPointer,
  output logic [7:0]        flagRegister,
  output logic [7:0]        instrReg,
  output logic [7:0]        accOut,
  output logic [15:0]       stackPtr,
  output logic [15:0]       indexReg,
  output logic              cpuClkRun,
  output logic              inBreak
);
  // ****************************************************************
  // State and helpers
  // ****************************************************************
  cfp_pkg::cfp_state_s s;
  cfp_pkg::cfp_state_s next_s;
  cfp_pkg::cfp_alu_s   alu;
  logic                boundary;
  logic                brkGo;
  logic                irqGo;
  logic                runCmd;

  // Lowest index wins, so index 0 is the highest priority.
  function automatic logic [NIRQ-1:0] firstReq(input logic [NIRQ-1:0] r);
    firstReq = r & NIRQ'(~r + 1'b1);
  endfunction

  function automatic logic [15:0] vecOf(input logic [NIRQ-1:0] oh);
    vecOf = `CFP_IRQ_VEC;
    for (int i = 0; i < NIRQ; i++) begin
      if (oh[i]) begin
        vecOf = `CFP_IRQ_VEC - 16'(2 * i);
      end
    end
  endfunction

  function automatic logic brTaken(input cfp_pkg::cfp_br_e c, input logic [7:0] f);
    logic nv;
    nv = f[`CFP_FL_N] ^ f[`CFP_FL_V];
    case (c)
      cfp_pkg::BR_GE: brTaken = ~nv;
      cfp_pkg::BR_GT: brTaken = ~(nv | f[`CFP_FL_Z]);
      cfp_pkg::BR_LE: brTaken = nv | f[`CFP_FL_Z];
      default:        brTaken = nv;
    endcase
  endfunction

  cfp_alu u_alu (
    .op   (cmd.op),
    .a    (s.acc),
    .m    (cmd.operand),
    .flIn (s.fl),
    .res  (alu)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s    = s;
    irqAck    = '0;
    memRd     = 1'b0;
    memWr     = 1'b0;
    memAddr   = s.sp;
    memWrData = 8'h00;
    irqGo     = 1'b0;
    brkGo     = 1'b0;
    boundary  = ~cmdValid | cmd.last;
    case (s.st)
      cfp_pkg::ST_VRD: begin
        memRd      = (s.cnt < `CFP_VRD_LAST);
        memAddr    = s.vec + {15'h0000, s.cnt[0]};
        next_s.cnt = s.cnt + 3'h1;
        if (s.cnt == 3'h1) begin
          next_s.pc[15:8] = memRdData;
        end
        if (s.cnt == `CFP_VRD_LAST) begin
          next_s.pc[7:0] = memRdData;
          next_s.st      = cfp_pkg::ST_RUN;
          next_s.cnt     = 3'h0;
        end
      end
      cfp_pkg::ST_RUN: begin
        if (cmdValid) begin
          case (cmd.op)
            cfp_pkg::OP_FETCH: begin
              next_s.pc = s.pc + 16'h0001;
            end
            cfp_pkg::OP_JUMP: begin
              next_s.pc = cmd.target;
            end
            cfp_pkg::OP_BRANCH: begin
              if (brTaken(cmd.cond, s.fl)) begin
                next_s.pc = cmd.target;
              end
            end
            cfp_pkg::OP_ADD, cfp_pkg::OP_ADC, cfp_pkg::OP_AND, cfp_pkg::OP_DAA, cfp_pkg::OP_ASL: begin
              next_s.acc = alu.res;
              next_s.fl  = alu.flags;
            end
            cfp_pkg::OP_AIS, cfp_pkg::OP_AIX: begin
              next_s.st    = cfp_pkg::ST_IMM;
              next_s.imm   = {{8{cmd.operand[7]}}, cmd.operand};
              next_s.immSp = (cmd.op == cfp_pkg::OP_AIS);
            end
            cfp_pkg::OP_CLI: begin
              next_s.fl[`CFP_FL_I] = 1'b0;
            end
            cfp_pkg::OP_RTI: begin
              next_s.st  = cfp_pkg::ST_PULL;
              next_s.cnt = 3'h0;
            end
            cfp_pkg::OP_SWI: begin
              next_s.st  = cfp_pkg::ST_PUSH;
              next_s.vec = `CFP_BRK_VEC;
              next_s.cnt = 3'h0;
            end
            cfp_pkg::OP_WAIT: begin
              next_s.fl[`CFP_FL_I] = 1'b0;
              next_s.st            = cfp_pkg::ST_WAIT;
            end
            cfp_pkg::OP_STOP: begin
              next_s.fl[`CFP_FL_I] = 1'b0;
              next_s.st            = cfp_pkg::ST_STOP;
            end
            default: begin
              next_s.st = cfp_pkg::ST_RUN;
            end
          endcase
        end
        // Break beats maskable requests at the same boundary.
        if (next_s.st == cfp_pkg::ST_RUN && boundary) begin
          brkGo = brkReq & ~s.brk;
          irqGo = ~brkGo & ~s.fl[`CFP_FL_I] & (|irqReq);
        end
      end
      cfp_pkg::ST_IMM: begin
        if (s.immSp) begin
          next_s.sp = s.sp + s.imm;
        end else begin
          {next_s.h, next_s.x} = {s.h, s.x} + s.imm;
        end
        next_s.st = cfp_pkg::ST_RUN;
      end
      cfp_pkg::ST_PUSH: begin
        memWr      = 1'b1;
        next_s.sp  = s.sp - 16'h0001;
        next_s.cnt = s.cnt + 3'h1;
        // Upper index byte is left for software to save.
        case (s.cnt)
          3'h0:    memWrData = s.pc[7:0];
          3'h1:    memWrData = s.pc[15:8];
          3'h2:    memWrData = s.x;
          3'h3:    memWrData = s.acc;
          default: memWrData = s.fl;
        endcase
        if (s.cnt == `CFP_PUSH_LAST) begin
          next_s.fl[`CFP_FL_I] = 1'b1;
          next_s.st            = cfp_pkg::ST_VRD;
          next_s.cnt           = 3'h0;
        end
      end
      cfp_pkg::ST_PULL: begin
        memRd      = (s.cnt < `CFP_PULL_LAST);
        memAddr    = s.sp + 16'h0001;
        next_s.cnt = s.cnt + 3'h1;
        if (s.cnt < `CFP_PULL_LAST) begin
          next_s.sp = s.sp + 16'h0001;
        end
        case (s.cnt)
          3'h1:    next_s.fl = memRdData;
          3'h2:    next_s.acc = memRdData;
          3'h3:    next_s.x = memRdData;
          3'h4:    next_s.pc[15:8] = memRdData;
          3'h5:    next_s.pc[7:0] = memRdData;
          default: next_s.cnt = 3'h1;
        endcase
        if (s.cnt == `CFP_PULL_LAST) begin
          next_s.st  = cfp_pkg::ST_RUN;
          next_s.cnt = 3'h0;
          if (s.brk && !brkReq) begin
            next_s.brk = 1'b0;
          end
        end
      end
      cfp_pkg::ST_WAIT: begin
        irqGo = |irqReq;
      end
      cfp_pkg::ST_STOP: begin
        // Only the external request, index 0, can wake from stop.
        if (irqReq[0]) begin
          next_s.st   = cfp_pkg::ST_STAB;
          next_s.stab = '0;
        end
      end
      cfp_pkg::ST_STAB: begin
        next_s.stab = s.stab + `CFP_STAB_W'(1);
        if (s.stab == `CFP_STAB_W'(STAB_CYCLES - 1)) begin
          next_s.st = cfp_pkg::ST_RUN;
          irqGo     = |irqReq;
        end
      end
      default: begin
        next_s.st = cfp_pkg::ST_RUN;
      end
    endcase
    if (brkGo) begin
      next_s.ir  = SOFT_TRAP_OP;
      next_s.brk = 1'b1;
      next_s.vec = monMode ? `CFP_MON_VEC : `CFP_BRK_VEC;
      next_s.st  = cfp_pkg::ST_PUSH;
      next_s.cnt = 3'h0;
    end
    if (irqGo) begin
      irqAck     = firstReq(irqReq);
      next_s.vec = vecOf(firstReq(irqReq));
      next_s.st  = cfp_pkg::ST_PUSH;
      next_s.cnt = 3'h0;
    end
    // Software writes override the core in the same cycle; a flag write keeps the core's mask bit.
    if (regWr && regAddr == `CFP_A_FP) begin
      next_s.pc = regWrData;
    end
    if (regWr && regAddr == `CFP_A_FL) begin
      next_s.fl = {regWrData[7:4], next_s.fl[`CFP_FL_I], regWrData[2:0]};
    end
    next_s.fl = next_s.fl | `CFP_FL_ONES;
    next_s.rdData = 16'h0000;
    if (regRd) begin
      case (regAddr)
        `CFP_A_FP: next_s.rdData = s.pc;
        `CFP_A_FL: next_s.rdData = {8'h00, s.fl};
        `CFP_A_ST: next_s.rdData = {7'h00, s.brk, s.st};
        default:   next_s.rdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s        <= '0;
      s.st     <= cfp_pkg::ST_VRD;
      s.vec    <= `CFP_RST_VEC;
      s.fl     <= `CFP_FL_RST;
      s.sp     <= `CFP_SP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdData    = s.rdData;
  assign cmdReady     = (s.st == cfp_pkg::ST_RUN);
  assign fetchPointer = s.pc;
  assign flagRegister = s.fl;
  assign instrReg     = s.ir;
  assign accOut       = s.acc;
  assign stackPtr     = s.sp;
  assign indexReg     = {s.h, s.x};
  assign inBreak      = s.brk;
  // The clock gate stays closed through the whole stop recovery.
  assign cpuClkRun    = ~(s.st inside {cfp_pkg::ST_WAIT, cfp_pkg::ST_STOP, cfp_pkg::ST_STAB});
  assign runCmd       = cmdReady & cmdValid & ~regWr;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_fetch_step : assert property (
    runCmd && cmd.op == cfp_pkg::OP_FETCH |=> s.pc == $past(s.pc) + 16'h0001)
    else $error("fetch pointer did not step by one");

  chk_jump_load : assert property (
    runCmd && cmd.op == cfp_pkg::OP_JUMP |=> s.pc == $past(cmd.target))
    else $error("jump target not loaded");

  chk_reset_vec : assert property (
    $past(rst) |-> memRd && memAddr == `CFP_RST_VEC ##1 memRd && memAddr == 16'hffff)
    else $error("reset vector not fetched");

  chk_fixed_ones : assert property (
    flagRegister[6:5] == 2'b11)
    else $error("fixed flag bits not one");

  chk_nibble_carry : assert property (
    runCmd && cmd.op == cfp_pkg::OP_ADD |=>
      flagRegister[`CFP_FL_H] == (({1'b0, $past(s.acc[3:0])} + {1'b0, $past(cmd.operand[3:0])}) > 5'h0f))
    else $error("nibble carry wrong");

  chk_sign_zero : assert property (
    runCmd && cmd.op == cfp_pkg::OP_AND |=> accOut == ($past(s.acc) & $past(cmd.operand)) &&
      flagRegister[`CFP_FL_N] == accOut[7] && flagRegister[`CFP_FL_Z] == (accOut == 8'h00))
    else $error("sign or zero flag wrong");

  chk_mask_block : assert property (
    cmdReady && s.fl[`CFP_FL_I] |-> irqAck == '0)
    else $error("request taken while masked");

  chk_push_mask : assert property (
    s.st == cfp_pkg::ST_PUSH && s.cnt == `CFP_PUSH_LAST |-> memWr ##1 s.fl[`CFP_FL_I] && memRd)
    else $error("mask not set between push and vector");

  chk_pull_mask : assert property (
    s.st == cfp_pkg::ST_PULL && s.cnt == 3'h1 && !regWr |=> s.fl[`CFP_FL_I] == $past(memRdData[`CFP_FL_I]))
    else $error("mask not restored from stack");

  chk_wait_enter : assert property (
    runCmd && cmd.op == cfp_pkg::OP_WAIT |=> !s.fl[`CFP_FL_I] && !cpuClkRun)
    else $error("wait entry wrong");

  chk_stab_hold : assert property (
    s.st == cfp_pkg::ST_STAB && s.stab < `CFP_STAB_W'(STAB_CYCLES - 1) |=> s.st == cfp_pkg::ST_STAB && !cpuClkRun)
    else $error("clock restarted before stabilization");

  chk_break_trap : assert property (
    cmdReady && !cmdValid && brkReq && !s.brk |=>
      s.st == cfp_pkg::ST_PUSH && s.ir == SOFT_TRAP_OP
      ##5 memRd && memAddr == ($past(monMode, 6) ? `CFP_MON_VEC : `CFP_BRK_VEC))
    else $error("break entry wrong");

  chk_break_end : assert property (
    s.st == cfp_pkg::ST_PULL && s.cnt == `CFP_PULL_LAST && s.brk && !brkReq |=> !s.brk)
    else $error("break not ended by return");

  chk_imm_add : assert property (
    runCmd && cmd.op == cfp_pkg::OP_AIS |=> !cmdReady ##1 cmdReady && s.fl == $past(s.fl, 2)
      && s.sp == $past(s.sp, 2) + {{8{$past(cmd.operand[7], 2)}}, $past(cmd.operand, 2)})
    else $error("stack immediate add wrong");

  cov_break_push : cover property (s.st == cfp_pkg::ST_PUSH && s.brk);
  cov_pull_done  : cover property (s.st == cfp_pkg::ST_PULL && s.cnt == `CFP_PULL_LAST);
  cov_stop_wake  : cover property (s.st == cfp_pkg::ST_STAB ##1 s.st == cfp_pkg::ST_STAB);
  cov_irq_take   : cover property (|irqAck);
endmodule

// *** cfp_params.svh ***
// Shared constants for the CPU flag and fetch pointer block.
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH
// ****************************************************************
// Vectors and reset values
// ****************************************************************
`define CFP_RST_VEC   16'hfffe
`define CFP_BRK_VEC   16'hfffc
`define CFP_MON_VEC   16'hfefc
`define CFP_IRQ_VEC   16'hfffa
`define CFP_SP_RST    16'h00ff
`define CFP_FL_RST    8'h68
`define CFP_FL_ONES   8'h60
`define CFP_STAB_CYC  4096
`define CFP_STAB_W    13
`define CFP_SOFT_TRAP 8'h00
// ****************************************************************
// Flag bit positions
// ****************************************************************
`define CFP_FL_V 7
`define CFP_FL_H 4
`define CFP_FL_I 3
`define CFP_FL_N 2
`define CFP_FL_Z 1
`define CFP_FL_C 0
// ****************************************************************
// Register addresses and sequence counts
// ****************************************************************
`define CFP_A_FP      4'h0
`define CFP_A_FL      4'h1
`define CFP_A_ST      4'h2
`define CFP_VRD_LAST  3'h2
`define CFP_PUSH_LAST 3'h4
`define CFP_PULL_LAST 3'h5
`endif

// *** cfp_pkg.sv ***
// Types shared by the CPU flag and fetch pointer block.
`include "cfp_params.svh"
package cfp_pkg;
  // ****************************************************************
  // Sequencer states and commands
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_VRD  = 8'h01,
    ST_RUN  = 8'h02,
    ST_IMM  = 8'h04,
    ST_PUSH = 8'h08,
    ST_PULL = 8'h10,
    ST_WAIT = 8'h20,
    ST_STOP = 8'h40,
    ST_STAB = 8'h80
  } cfp_state_e;

  typedef enum logic [3:0] {
    OP_NOP, OP_FETCH, OP_JUMP, OP_BRANCH, OP_ADD, OP_ADC, OP_AND, OP_DAA,
    OP_ASL, OP_AIS, OP_AIX, OP_CLI, OP_RTI, OP_SWI, OP_WAIT, OP_STOP
  } cfp_op_e;

  typedef enum logic [1:0] {BR_GE, BR_GT, BR_LE, BR_LT} cfp_br_e;

  typedef struct packed {
    cfp_op_e     op;
    cfp_br_e     cond;
    logic        last;
    logic [7:0]  operand;
    logic [15:0] target;
  } cfp_cmd_s;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
  } cfp_alu_s;

  typedef struct packed {
    cfp_state_e             st;
    logic [2:0]             cnt;
    logic [15:0]            pc;
    logic [7:0]             fl;
    logic [7:0]             acc;
    logic [7:0]             x;
    logic [7:0]             h;
    logic [15:0]            sp;
    logic [15:0]            vec;
    logic [7:0]             ir;
    logic                   brk;
    logic [`CFP_STAB_W-1:0] stab;
    logic [15:0]            rdData;
    logic [15:0]            imm;
    logic                   immSp;
  } cfp_state_s;
endpackage

// *** cfp_alu.sv ***
// Accumulator arithmetic and flag computation for the CPU control core.
`include "cfp_params.svh"
module cfp_alu (
  input  cfp_pkg::cfp_op_e  op,
  input  logic [7:0]        a,
  input  logic [7:0]        m,
  input  logic [7:0]        flIn,
  output cfp_pkg::cfp_alu_s res
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic       cin;
  logic       lo;
  logic       hi;
  logic       upd;
  logic [7:0] r;
  logic [7:0] f;
  logic [7:0] corr;

  always_comb begin
    cin  = (op == cfp_pkg::OP_ADC) & flIn[`CFP_FL_C];
    sum  = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    nib  = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    lo   = flIn[`CFP_FL_H] | (a[3:0] > 4'h9);
    hi   = flIn[`CFP_FL_C] | (a[7:4] > 4'h9) | ((a[7:4] > 4'h8) & (a[3:0] > 4'h9));
    corr = {(hi ? 4'h6 : 4'h0), (lo ? 4'h6 : 4'h0)};
    r    = a;
    f    = flIn;
    upd  = 1'b0;
    case (op)
      cfp_pkg::OP_ADD, cfp_pkg::OP_ADC: begin
        r            = sum[7:0];
        f[`CFP_FL_V] = (a[7] == m[7]) & (r[7] != a[7]);
        f[`CFP_FL_H] = nib[4];
        f[`CFP_FL_C] = sum[8];
        upd          = 1'b1;
      end
      cfp_pkg::OP_AND: begin
        r            = a & m;
        f[`CFP_FL_V] = 1'b0;
        upd          = 1'b1;
      end
      cfp_pkg::OP_DAA: begin
        r            = a + corr;
        f[`CFP_FL_C] = hi;
        upd          = 1'b1;
      end
      cfp_pkg::OP_ASL: begin
        r            = {a[6:0], 1'b0};
        f[`CFP_FL_C] = a[7];
        f[`CFP_FL_V] = r[7] ^ a[7];
        upd          = 1'b1;
      end
      default: begin
        upd = 1'b0;
      end
    endcase
    if (upd) begin
      f[`CFP_FL_N] = r[7];
      f[`CFP_FL_Z] = (r == 8'h00);
    end
    res.res   = r;
    res.flags = f;
  end
endmodule

// *** cfp_mem_model.sv ***
// Behavioural memory that answers the core's stack and vector cycles.
module cfp_mem_model (
  input  logic        clk,
  input  logic [15:0] memAddr,
  input  logic        memRd,
  input  logic        memWr,
  input  logic [7:0]  memWrData,
  output logic [7:0]  memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] store [0:65535];
  initial memRdData = 8'h00;
  // Read data stand only in the cycle after the strobe; at other times the
  // bus shows the inverse of its last value, so a late sample gets no stale byte.
  always @(posedge clk) begin
    if (memWr) begin
      store[memAddr] <= memWrData;
    end
    memRdData <= memRd ? store[memAddr] : ~memRdData;
  end
endmodule

// *** cfp_core_tb.sv ***
// Self-checking bench for the CPU flag and fetch pointer core.
module cfp_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic              clk, rst, regWr, regRd, cmdValid, brkReq, monMode;
  logic              cmdReady, memRd, memWr, cpuClkRun, inBreak;
  logic [3:0]        regAddr, irqReq, irqAck, ack;
  logic [7:0]        memWrData, memRdData, flagRegister, instrReg, accOut;
  logic [15:0]       regWrData, regRdData, memAddr, fetchPointer, stackPtr, indexReg, rd;
  cfp_pkg::cfp_cmd_s cmd;
  int                mismatches, checked, n;

  cfp_core #(.STAB_CYCLES(8), .SOFT_TRAP_OP(8'h5a)) dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
    .irqReq(irqReq), .irqAck(irqAck), .brkReq(brkReq), .monMode(monMode), .memAddr(memAddr),
    .memRd(memRd), .memWr(memWr), .memWrData(memWrData), .memRdData(memRdData),
    .fetchPointer(fetchPointer), .flagRegister(flagRegister), .instrReg(instrReg),
    .accOut(accOut), .stackPtr(stackPtr), .indexReg(indexReg), .cpuClkRun(cpuClkRun),
    .inBreak(inBreak)
  );
  cfp_mem_model u_mem (
    .clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWrData(memWrData),
    .memRdData(memRdData)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task vec(input logic [15:0] a, input logic [15:0] v);
    u_mem.store[a] = v[15:8];
    u_mem.store[a+16'h0001] = v[7:0];
  endtask
  // Always waits at least one cycle, so a sequence that has just begun is not mistaken for idle.
  task waitReady;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 9000);
  endtask
  task doCmd(input cfp_pkg::cfp_op_e op, input logic [7:0] opd, input logic [15:0] tgt,
             input cfp_pkg::cfp_br_e c);
    waitReady;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= '{op: op, cond: c, last: 1'b0, operand: opd, target: tgt};
    @(negedge clk);
    while (cmdReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
  endtask
  task aluStep(input cfp_pkg::cfp_op_e op, input logic [7:0] opd, input logic [7:0] expA,
               input logic [7:0] expF);
    doCmd(op, opd, 16'h0000, cfp_pkg::BR_GE);
    check("acc", 16'(accOut), 16'(expA));
    check("flags", 16'(flagRegister), 16'(expF));
  endtask
  task regRead(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask
  task regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task waitAck(input logic [3:0] req);
    @(posedge clk);
    irqReq <= req;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irqAck === 4'h0 && n < 200);
    ack = irqAck;
    @(posedge clk);
    irqReq <= 4'h0;
    waitReady;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #200000;
    mismatches++;
    test_done;
  end
  initial begin
    rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWrData = 16'h0000;
    cmdValid = 1'b0; cmd = '0; irqReq = 4'h0; brkReq = 1'b0; monMode = 1'b0; ack = 4'h0;
    vec(16'hfffe, 16'h1234); vec(16'hfff8, 16'h2000); vec(16'hfff6, 16'h5000);
    vec(16'hfffa, 16'h4000); vec(16'hfefc, 16'h3000); vec(16'hfffc, 16'h6000);
    repeat (20) @(posedge clk);
    check("flags", 16'(flagRegister), 16'h0068);
    rst <= 1'b0;
    waitReady;
    check("pc", fetchPointer, 16'h1234);
    regWrite(4'h1, 16'h0000);
    regRead(4'h1, rd);
    check("flags", rd, 16'h0068);
    regRead(4'hf, rd);
    check("unmapped", rd, 16'h0000);
    regRead(4'h2, rd);
    check("status", rd, 16'h0002);
    @(negedge clk);
    check("rddata", regRdData, 16'h0000);
    aluStep(cfp_pkg::OP_ADD, 8'h08, 8'h08, 8'h68);
    aluStep(cfp_pkg::OP_ADD, 8'h08, 8'h10, 8'h78);
    doCmd(cfp_pkg::OP_DAA, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    check("acc", 16'(accOut), 16'h0016);
    aluStep(cfp_pkg::OP_ADD, 8'h6a, 8'h80, 8'hfc);
    aluStep(cfp_pkg::OP_ADD, 8'h80, 8'h00, 8'heb);
    aluStep(cfp_pkg::OP_ADC, 8'h0f, 8'h10, 8'h78);
    aluStep(cfp_pkg::OP_AND, 8'h00, 8'h00, 8'h7a);
    aluStep(cfp_pkg::OP_ADD, 8'hff, 8'hff, 8'h6c);
    aluStep(cfp_pkg::OP_ASL, 8'h00, 8'hfe, 8'h6d);
    aluStep(cfp_pkg::OP_ADD, 8'h01, 8'hff, 8'h6c);
    doCmd(cfp_pkg::OP_FETCH, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    check("pc", fetchPointer, 16'h1235);
    doCmd(cfp_pkg::OP_JUMP, 8'h00, 16'h0abc, cfp_pkg::BR_GE);
    check("pc", fetchPointer, 16'h0abc);
    doCmd(cfp_pkg::OP_BRANCH, 8'h00, 16'h0def, cfp_pkg::BR_LT);
    check("pc", fetchPointer, 16'h0def);
    doCmd(cfp_pkg::OP_BRANCH, 8'h00, 16'h0123, cfp_pkg::BR_GE);
    check("pc", fetchPointer, 16'h0def);
    doCmd(cfp_pkg::OP_BRANCH, 8'h00, 16'h0111, cfp_pkg::BR_GT);
    check("pc", fetchPointer, 16'h0def);
    doCmd(cfp_pkg::OP_AIS, 8'hff, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("sp", stackPtr, 16'h00fe);
    doCmd(cfp_pkg::OP_AIX, 8'h80, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("hx", indexReg, 16'hff80);
    check("flags", 16'(flagRegister), 16'h006c);
    @(posedge clk);
    irqReq <= 4'b1010;
    repeat (10) begin
      @(negedge clk);
      ack = ack | irqAck;
    end
    check("ack", 16'(ack), 16'h0000);
    doCmd(cfp_pkg::OP_CLI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    @(posedge clk);
    irqReq <= 4'h0;
    check("pc", fetchPointer, 16'h2000);
    check("flags", 16'(flagRegister), 16'h006c);
    check("sp", stackPtr, 16'h00f9);
    check("pcl", 16'(u_mem.store[16'h00fe]), 16'h00ef);
    check("stflags", 16'(u_mem.store[16'h00fa]), 16'h0064);
    doCmd(cfp_pkg::OP_WAIT, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    check("clkrun", 16'(cpuClkRun), 16'h0000);
    check("flags", 16'(flagRegister), 16'h0064);
    waitAck(4'b0100);
    check("ack", 16'(ack), 16'h0004);
    check("pc", fetchPointer, 16'h5000);
    doCmd(cfp_pkg::OP_RTI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("pc", fetchPointer, 16'h2000);
    check("flags", 16'(flagRegister), 16'h0064);
    doCmd(cfp_pkg::OP_RTI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("pc", fetchPointer, 16'h0def);
    doCmd(cfp_pkg::OP_STOP, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    check("clkrun", 16'(cpuClkRun), 16'h0000);
    waitAck(4'b0001);
    check("stab", 16'(n >= 8), 16'h0001);
    check("pc", fetchPointer, 16'h4000);
    doCmd(cfp_pkg::OP_RTI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    doCmd(cfp_pkg::OP_SWI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("pc", fetchPointer, 16'h6000);
    check("brk", 16'(inBreak), 16'h0000);
    doCmd(cfp_pkg::OP_RTI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("pc", fetchPointer, 16'h0def);
    @(posedge clk);
    brkReq <= 1'b1;
    monMode <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (inBreak !== 1'b1 && n < 100);
    check("ir", 16'(instrReg), 16'h005a);
    waitReady;
    check("pc", fetchPointer, 16'h3000);
    @(posedge clk);
    brkReq <= 1'b0;
    monMode <= 1'b0;
    doCmd(cfp_pkg::OP_RTI, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    waitReady;
    check("brk", 16'(inBreak), 16'h0000);
    check("pc", fetchPointer, 16'h0def);
    doCmd(cfp_pkg::OP_WAIT, 8'h00, 16'h0000, cfp_pkg::BR_GE);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    waitReady;
    check("flags", 16'(flagRegister), 16'h0068);
    check("pc", fetchPointer, 16'h1234);
    check("clkrun", 16'(cpuClkRun), 16'h0001);
    test_done;
  end
endmodule
